/* design/pulc_lock_ctrl.sv */
`include "pulc_cfg.svh"
module pulc_lock_ctrl
  import pulc_pkg::*;
#(
  parameter int RELEASE_CYC = `PULC_RELEASE_CYC,
  parameter int SETTLE_CYC = `PULC_SETTLE_CYC,
  parameter int UNLOCK_CYC = `PULC_UNLOCK_CYC,
  parameter logic [29:0] UNLOCK_KEY = 30'h15A5A5A5 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // supply comparators
  input wire logic supply_above_release,
  input wire logic supply_below_reassert,
  // decoded command frames
  input wire pulc_pkg::pulc_cmd_t cmd,
  output pulc_pkg::pulc_rsp_t rsp,
  // stored permanent lock bit, nonvolatile copy
  input wire logic nv_lock_bit,
  // outputs
  output logic core_reset_n,
  output logic out_enable,
  output logic access_open,
  output logic permanent_write_lock,
  output logic [23:0] gain_trim,
  output logic [23:0] offset_trim
);
  localparam int CW = $clog2(UNLOCK_CYC + 1);

  typedef struct packed {
    pulc_state_t state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] win;
    logic win_open;
    logic unlocked;
    logic lock_active;
    logic lock_req;
    logic strap_done;
    logic rd_pend;
    logic [5:0] rd_addr;
    pulc_rsp_t rsp;
  } pulc_st_t;

  pulc_st_t st_ff;
  pulc_st_t nxt_st;
  logic [23:0] mem_rd;
  logic mem_wr;
  logic trim_hit;
  logic write_ok;
  logic read_ok;

  // powered-down means supply under the lower threshold
  wire power_fail = supply_below_reassert;

  assign trim_hit = (cmd.addr == `PULC_OFS_GAIN_TRIM) || (cmd.addr == `PULC_OFS_OFFSET_TRIM);
  assign write_ok = cmd.valid && !cmd.is_read && st_ff.unlocked && !st_ff.lock_active;
  assign read_ok = cmd.valid && cmd.is_read && st_ff.unlocked;
  assign mem_wr = write_ok && trim_hit;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.valid = 1'b0;
    unique case (st_ff.state)
      PULC_ST_RESET: begin
        nxt_st.cnt = '0;
        if (supply_above_release && !power_fail) nxt_st.state = PULC_ST_COUNT;
      end
      PULC_ST_COUNT: begin
        if (!supply_above_release) begin
          nxt_st.state = PULC_ST_RESET;
        end else if (st_ff.cnt == CW'(RELEASE_CYC - 1)) begin
          nxt_st.state = PULC_ST_SETTLE;
          nxt_st.cnt = '0;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      PULC_ST_SETTLE: begin
        if (st_ff.cnt == CW'(SETTLE_CYC - 1)) nxt_st.state = PULC_ST_RUN;
        else nxt_st.cnt = st_ff.cnt + 1'b1;
      end
      PULC_ST_RUN: ;
    endcase
    // unlock window runs from reset and from the end of a supply dip, not from core reset release
    if (st_ff.win_open) begin
      if (st_ff.win == CW'(UNLOCK_CYC - 1)) nxt_st.win_open = 1'b0;
      else nxt_st.win = st_ff.win + 1'b1;
    end
    if (cmd.valid && !cmd.is_read && cmd.addr == `PULC_OFS_UNLOCK_KEY) begin
      // wrong or late key simply leaves the lock as it is
      // stored lock not yet picked up on the first edge, so look at it directly
      if (st_ff.win_open && !st_ff.lock_active && !(nv_lock_bit && !st_ff.strap_done) &&
          cmd.data == UNLOCK_KEY) nxt_st.unlocked = 1'b1;
    end
    if (write_ok && cmd.addr == `PULC_OFS_LOCK_CTRL) begin
      // takes effect only after the next power cycle
      nxt_st.lock_req = cmd.data[`PULC_LOCK_BIT] | st_ff.lock_req;
    end
    if (read_ok) begin
      nxt_st.rd_pend = 1'b1;
      nxt_st.rd_addr = cmd.addr;
    end
    if (st_ff.rd_pend) begin
      nxt_st.rd_pend = 1'b0;
      nxt_st.rsp.valid = 1'b1;
      unique case (st_ff.rd_addr)
        `PULC_OFS_GAIN_TRIM, `PULC_OFS_OFFSET_TRIM: nxt_st.rsp.data = {6'h00, mem_rd};
        `PULC_OFS_LOCK_CTRL: nxt_st.rsp.data = {29'h0, st_ff.lock_req};
        `PULC_OFS_STATUS: nxt_st.rsp.data = {26'h0, st_ff.lock_active, st_ff.unlocked, st_ff.state};
        default: nxt_st.rsp.data = '0;
      endcase
    end
    // stored lock taken once on the first edge after reset, kept in state
    if (!st_ff.strap_done) begin
      nxt_st.strap_done = 1'b1;
      nxt_st.lock_active = st_ff.lock_active | nv_lock_bit;
      nxt_st.lock_req = st_ff.lock_req | nv_lock_bit;
    end
    // supply collapse restarts the sequencer, unlock window, unlock and pending read; lock request is kept and made active
    if (power_fail) begin
      nxt_st.state = PULC_ST_RESET;
      nxt_st.cnt = '0;
      nxt_st.win = '0;
      nxt_st.win_open = 1'b1;
      nxt_st.unlocked = 1'b0;
      nxt_st.rd_pend = 1'b0;
      nxt_st.lock_active = st_ff.lock_active | st_ff.lock_req | nv_lock_bit;
      nxt_st.lock_req = st_ff.lock_req | nv_lock_bit;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{state: PULC_ST_RESET, cnt: '0, win: '0, win_open: 1'b1, unlocked: 1'b0,
                 lock_active: 1'b0, lock_req: 1'b0, strap_done: 1'b0, rd_pend: 1'b0, rd_addr: '0,
                 rsp: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  pulc_trim_mem #(
    .DW(24)
  ) u_trim (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(mem_wr),
    .wr_sel(cmd.addr == `PULC_OFS_OFFSET_TRIM),
    .wr_data(cmd.data[23:0]),
    .rd_sel(cmd.addr == `PULC_OFS_OFFSET_TRIM),
    .rd_data(mem_rd),
    .gain_trim(gain_trim),
    .offset_trim(offset_trim)
  );

  assign core_reset_n = (st_ff.state == PULC_ST_SETTLE) || (st_ff.state == PULC_ST_RUN);
  assign out_enable = (st_ff.state == PULC_ST_RUN);
  assign access_open = st_ff.unlocked && !st_ff.lock_active;
  assign permanent_write_lock = st_ff.lock_active;
  assign rsp = st_ff.rsp;
endmodule : pulc_lock_ctrl

/* include/pulc_cfg.svh */
`ifndef PULC_CFG_SVH
`define PULC_CFG_SVH
`define PULC_CLK_MHZ 250
`define PULC_ADDR_W 6
`define PULC_DATA_W 30
`define PULC_OFS_UNLOCK_KEY 6'h24
`define PULC_OFS_GAIN_TRIM 6'h01
`define PULC_OFS_OFFSET_TRIM 6'h02
`define PULC_OFS_LOCK_CTRL 6'h03
`define PULC_OFS_STATUS 6'h04
`define PULC_LOCK_BIT 0
`define PULC_RELEASE_US 64
`define PULC_SETTLE_US 16
`define PULC_UNLOCK_WINDOW_MS 8
`define PULC_RELEASE_CYC (`PULC_RELEASE_US * `PULC_CLK_MHZ)
`define PULC_SETTLE_CYC (`PULC_SETTLE_US * `PULC_CLK_MHZ)
`define PULC_UNLOCK_CYC (`PULC_UNLOCK_WINDOW_MS * 1000 * `PULC_CLK_MHZ)
`define PULC_GAIN_RST 24'h000000
`define PULC_OFFSET_RST 24'h000000
`endif

/* include/pulc_pkg.sv */
package pulc_pkg;
  typedef enum logic [1:0] {
    PULC_ST_RESET = 2'b00,
    PULC_ST_COUNT = 2'b01,
    PULC_ST_SETTLE = 2'b10,
    PULC_ST_RUN = 2'b11
  } pulc_state_t;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic [5:0] addr;
    logic [29:0] data;
  } pulc_cmd_t;

  typedef struct packed {
    logic valid;
    logic [29:0] data;
  } pulc_rsp_t;
endpackage : pulc_pkg

/* design/pulc_trim_mem.sv */
`include "pulc_cfg.svh"
module pulc_trim_mem #(
  parameter int DW = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // write port
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic [DW-1:0] wr_data,
  // read port, registered
  input wire logic rd_sel,
  output logic [DW-1:0] rd_data,
  // trim values to the analog path
  output logic [DW-1:0] gain_trim,
  output logic [DW-1:0] offset_trim
);
  typedef struct packed {
    logic [DW-1:0] gain;
    logic [DW-1:0] offset;
    logic [DW-1:0] rd;
  } pulc_mem_st_t;
  pulc_mem_st_t st_ff;
  pulc_mem_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en && !wr_sel) nxt_st.gain = wr_data;
    if (wr_en && wr_sel) nxt_st.offset = wr_data;
    nxt_st.rd = rd_sel ? st_ff.offset : st_ff.gain;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{gain: DW'(`PULC_GAIN_RST), offset: DW'(`PULC_OFFSET_RST), rd: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd;
  assign gain_trim = st_ff.gain;
  assign offset_trim = st_ff.offset;
endmodule : pulc_trim_mem

/* verification/pulc_lock_ctrl_properties.sv */
module pulc_lock_ctrl_properties
  import pulc_pkg::*;
#(
  parameter int RELEASE_CYC = 8,
  parameter int SETTLE_CYC = 4,
  parameter logic [29:0] UNLOCK_KEY = 30'h0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire logic supply_above_release,
  input wire logic supply_below_reassert,
  input wire pulc_pkg::pulc_cmd_t cmd,
  input wire pulc_pkg::pulc_rsp_t rsp,
  input wire logic core_reset_n,
  input wire logic out_enable,
  input wire logic access_open,
  input wire logic permanent_write_lock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] up_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // run of good supply cycles, cleared by any dip
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_ff <= '0;
    end else begin
      up_ff <= (supply_above_release && !supply_below_reassert) ? up_ff + 16'h1 : '0;
    end
  end
  a_out_in_reset: assert property (out_enable |-> core_reset_n)
    else $error("output on in reset");
  a_release_early: assert property ($rose(core_reset_n) |-> up_ff > RELEASE_CYC)
    else $error("early release");
  a_fail_tristate: assert property (supply_below_reassert |-> ##[1:2] !(out_enable || core_reset_n))
    else $error("no reset on fail");
  // settle phase lasts exactly its count before the output drives
  a_settle_gap: assert property ($rose(out_enable) |->
    $past(core_reset_n, SETTLE_CYC) && !$past(core_reset_n, SETTLE_CYC + 1)) else $error("settle length");
  a_read_gated: assert property (rsp.valid |-> $past(cmd.valid && cmd.is_read && access_open, 2))
    else $error("read answered while locked");
  a_fail_relocks: assert property (supply_below_reassert |-> ##[1:2] !access_open)
    else $error("lock kept over fail");
  a_perm_closed: assert property (permanent_write_lock |-> !access_open)
    else $error("open under lock");
  a_lock_sticky: assert property (permanent_write_lock |=> permanent_write_lock)
    else $error("permanent lock cleared");
  a_bad_key: assert property (cmd.valid && !cmd.is_read && cmd.addr == 6'h24 && cmd.data != UNLOCK_KEY
    && !access_open |=> !access_open [*2]) else $error("wrong key opened");
endmodule : pulc_lock_ctrl_properties
bind pulc_lock_ctrl pulc_lock_ctrl_properties #(.RELEASE_CYC(RELEASE_CYC), .SETTLE_CYC(SETTLE_CYC),
  .UNLOCK_KEY(UNLOCK_KEY)) i_pulc_lock_ctrl_properties (.clk, .reset_n, .supply_above_release,
  .supply_below_reassert, .cmd, .rsp, .core_reset_n, .out_enable, .access_open, .permanent_write_lock);

/* verification/pulc_prog_model.sv */
module pulc_prog_model (
  // clock
  input wire logic clk,
  // supply and frames
  output logic supply_above_release,
  output logic supply_below_reassert,
  output pulc_pkg::pulc_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  import pulc_pkg::*;
  initial begin
    supply_above_release = 1'b0;
    supply_below_reassert = 1'b1;
    cmd = '0;
  end
  task automatic supply(input logic on);
    @(posedge clk);
    supply_above_release <= on;
    supply_below_reassert <= !on;
  endtask : supply
  task automatic send(input logic rd, input logic [5:0] a, input logic [29:0] d);
    @(posedge clk);
    cmd <= {1'b1, rd, a, d};
    @(posedge clk);
    // released fields must not look like a held frame
    cmd <= {1'b0, !rd, ~a, ~d};
  endtask : send
endmodule : pulc_prog_model

/* verification/test_power_up_lock_control.sv */
module test_power_up_lock_control;
  timeunit 1ns;
  timeprecision 100ps;
  import pulc_pkg::*;
  localparam logic [29:0] KEY = 30'h12345678; // arbitrary value
  localparam int REL_CYC = 8;
  localparam int SET_CYC = 4;
  localparam int WIN_CYC = 50;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic nv_lock_bit = 1'b0;
  logic up, dn, cor, oen, acc, pwl;
  logic [23:0] gt, ot;
  logic [29:0] d;
  pulc_cmd_t cmd;
  pulc_rsp_t rsp;
  int errors = 0;
  int cmp_count = 0;
  int seed = 34;
  int gain_m = 0;
  int ofs_m = 0;
  always #2 clk = ~clk;
  pulc_prog_model i_pulc_prog_model (.clk, .supply_above_release(up), .supply_below_reassert(dn), .cmd);
  pulc_lock_ctrl #(.RELEASE_CYC(REL_CYC), .SETTLE_CYC(SET_CYC), .UNLOCK_CYC(WIN_CYC), .UNLOCK_KEY(KEY))
  i_pulc_lock_ctrl (
    .clk, .reset_n, .supply_above_release(up), .supply_below_reassert(dn), .cmd, .rsp, .nv_lock_bit,
    .core_reset_n(cor), .out_enable(oen), .access_open(acc), .permanent_write_lock(pwl), .gain_trim(gt),
    .offset_trim(ot));
  task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic op(input logic r, input logic [5:0] a, input logic [29:0] v);
    i_pulc_prog_model.send(r, a, v);
    // read answer stands for one cycle only, right after this edge
    @(posedge clk);
    #1;
  endtask : op
  task automatic pwr(input logic on);
    int n;
    i_pulc_prog_model.supply(on);
    repeat (7) @(posedge clk);
    #1;
    chk({oen, cor}, 2'b0);
    n = 0;
    while (on && oen !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    // count starts one edge after the supply change, 7 edges already waited
    chk(n, on ? REL_CYC + SET_CYC - 6 : 0);
    chk({oen, acc}, {on, 1'b0});
  endtask : pwr
  task automatic rd(input logic [5:0] a, input int exp);
    op(1'b1, a, '0);
    chk({rsp.valid, rsp.data[23:0]}, {1'b1, exp[23:0]});
  endtask : rd
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    pwr(1'b1);
    op(1'b1, 6'h01, '0);
    chk(rsp.valid, 1'b0);
    op(1'b0, 6'h01, 30'h3FFFFFFF);
    op(1'b0, 6'h24, ~KEY);
    chk(acc, 1'b0);
    op(1'b0, 6'h24, KEY);
    chk(acc, 1'b1);
    rd(6'h01, gain_m);
    for (int i = 0; i < 4; i++) begin
      d = 30'($random(seed));
      gain_m = int'(d[23:0]);
      ofs_m = int'(~d[23:0]);
      op(1'b0, 6'h01, d);
      op(1'b0, 6'h02, ~d);
      rd(6'h01, gain_m);
      rd(6'h02, ofs_m);
      chk({gt, 6'h0}, {gain_m[23:0], 6'h0});
      chk({ot, 6'h0}, {ofs_m[23:0], 6'h0});
    end
    pwr(1'b0);
    pwr(1'b1);
    repeat (WIN_CYC) @(posedge clk);
    op(1'b0, 6'h24, KEY);
    chk(acc, 1'b0);
    pwr(1'b0);
    pwr(1'b1);
    op(1'b0, 6'h24, KEY);
    op(1'b0, 6'h03, 30'h1);
    chk({pwl, acc}, 2'b01);
    pwr(1'b0);
    pwr(1'b1);
    op(1'b0, 6'h24, KEY);
    chk({pwl, acc}, 2'b10);
    d = {6'h0, gt};
    op(1'b0, 6'h01, ~d);
    chk({6'h0, gt}, d);
    // reset while powered down with the stored lock bit set
    pwr(1'b0);
    @(posedge clk);
    nv_lock_bit <= 1'b1;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    pwr(1'b1);
    op(1'b0, 6'h24, KEY);
    chk({pwl, acc}, 2'b10);
    stop_test;
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    stop_test;
  end
endmodule : test_power_up_lock_control
